//--- hdl/isr_map.vh
`ifndef ISR_MAP_VH
`define ISR_MAP_VH

// ****************************************************************
// Memory geometry.
// ****************************************************************
`define ISR_WORDS       1024
`define ISR_IDX_W       10
`define ISR_IDX_LSB     2
`define ISR_IDX_MSB     11
`define ISR_BASE_LSB    12
`define ISR_BASE_MSB    31

// ****************************************************************
// Target timing and test bit.
// ****************************************************************
`define ISR_WAIT_STATES 2'h3
`define ISR_TEST_BIT    3
`define ISR_ZERO32      32'h0000_0000
`define ISR_ZERO20      20'h0_0000

`endif

//--- hdl/isr_mem.v
`timescale 1ns/1ps
`include "isr_map.vh"

// ****************************************************************
// Byte-writable word memory with registered read data.
// ****************************************************************
module isr_mem (
    input  wire        clk,
    input  wire        wr_en,
    input  wire [3:0]  wr_be,
    input  wire [9:0]  wr_idx,
    input  wire [31:0] wr_data,
    input  wire [9:0]  rd_idx,
    output reg  [31:0] rd_data
);
    reg [31:0] mem [0:`ISR_WORDS-1];

    // Each byte lane is written on its own enable.
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : lane
            always @(posedge clk) begin
                if (wr_en && wr_be[g]) begin
                    mem[wr_idx][g*8 +: 8] <= wr_data[g*8 +: 8];
                end
            end
        end
    endgenerate

    // Read data come out of a register.
    always @(posedge clk) begin
        rd_data <= mem[rd_idx];
    end
endmodule

//--- hdl/isr_ram.v
`timescale 1ns/1ps
`include "isr_map.vh"

// ****************************************************************
// Internal script memory: PCI target port, script fetch port and
// base mirror for the second scratch register.
// ****************************************************************
// The memory has one read port, shared by the target and the fetch path.
// A fetch that hits the window while the target machine is idle wins the
// port for that cycle, and the target request is held off until later.
// A fetch that arrives while a target access is in flight is not taken,
// because the target read data are captured from the shared port.
// The requester must therefore keep fetches away from target accesses.
// The enable strap is caught once after reset and never again, so a
// board change of the strap only takes effect at the next reset.
// The base register keeps only the 4 Kbyte aligned part of what is written.
// Instruction and table fetches are handled in the same way.
module isr_ram (
    input  wire        clk,
    input  wire        reset,
    input  wire        ram_enable_strap,
    input  wire        base_wr,
    input  wire [31:0] base_wr_data,
    input  wire        chip_test_bit3,
    input  wire [31:0] scratch_value,
    output reg  [31:0] second_scratch_reg,
    input  wire        tgt_req,
    input  wire        tgt_write,
    input  wire [31:0] tgt_addr,
    input  wire [3:0]  tgt_be_n,
    input  wire [31:0] tgt_wdata,
    output reg         tgt_claim,
    output reg         tgt_ready,
    output reg  [31:0] tgt_rdata,
    input  wire        fetch_req,
    input  wire        fetch_table,
    input  wire [31:0] fetch_addr,
    output reg         fetch_internal,
    output reg         fetch_valid,
    output reg  [31:0] fetch_data,
    input  wire        dev_req,
    output reg         dev_use_pci,
    output reg         ram_enabled,
    output reg  [31:0] ram_base
);
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_DONE = 2'd2;

    reg        strap_taken_reg;
    reg [1:0]  state_reg;
    reg [1:0]  wait_reg;
    reg        twr_reg;
    reg [3:0]  tbe_reg;
    reg [9:0]  tidx_reg;
    reg [31:0] twd_reg;
    reg        fpend_reg;
    wire [31:0] rd_data;
    wire        fetch_hit;
    wire        tgt_hit;
    wire        mem_wr;
    wire [9:0]  rd_idx;
    wire        fetch_take;

    // ****************************************************************
    // Window decode.
    // ****************************************************************
    // Window decode on 4 Kbyte boundary against the programmed base.
    assign tgt_hit = ram_enabled &&
        (tgt_addr[`ISR_BASE_MSB:`ISR_BASE_LSB] ==
         ram_base[`ISR_BASE_MSB:`ISR_BASE_LSB]);
    assign fetch_hit = ram_enabled &&
        (fetch_addr[`ISR_BASE_MSB:`ISR_BASE_LSB] ==
         ram_base[`ISR_BASE_MSB:`ISR_BASE_LSB]);
    assign mem_wr = (state_reg == ST_WAIT) && (wait_reg == 2'd0) && twr_reg;
    // A fetch is only taken while the target machine is idle.
    assign fetch_take = (state_reg == ST_IDLE) && fetch_req && fetch_hit;
    assign rd_idx = fetch_take ?
        fetch_addr[`ISR_IDX_MSB:`ISR_IDX_LSB] : tidx_reg;

    // ****************************************************************
    // Memory array.
    // ****************************************************************
    // The array is written by the target path only.
    isr_mem u_mem (
        .clk     (clk),
        .wr_en   (mem_wr),
        .wr_be   (tbe_reg),
        .wr_idx  (tidx_reg),
        .wr_data (twd_reg),
        .rd_idx  (rd_idx),
        .rd_data (rd_data)
    );

    // ****************************************************************
    // Enable strap.
    // ****************************************************************
    // Strap is caught on the first clock after reset release.
    always @(posedge clk) begin
        if (reset) begin
            strap_taken_reg <= 1'b0;
            ram_enabled     <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            ram_enabled     <= ram_enable_strap;
        end
    end

    // ****************************************************************
    // Base register.
    // ****************************************************************
    // Base register from configuration space, full 32-bit placement.
    always @(posedge clk) begin
        if (reset) begin
            ram_base <= `ISR_ZERO32;
        end else if (base_wr) begin
            ram_base <= {base_wr_data[`ISR_BASE_MSB:`ISR_BASE_LSB],
                         12'h000};
        end
    end

    // ****************************************************************
    // Scratch mirror.
    // ****************************************************************
    // Scratch readback shows the base while the test bit is set.
    always @(posedge clk) begin
        if (reset) begin
            second_scratch_reg <= `ISR_ZERO32;
        end else begin
            second_scratch_reg <= chip_test_bit3 ? ram_base : scratch_value;
        end
    end

    // ****************************************************************
    // Device master path.
    // ****************************************************************
    // Other device accesses are routed out as PCI master cycles.
    always @(posedge clk) begin
        if (reset) begin
            dev_use_pci <= 1'b0;
        end else begin
            dev_use_pci <= dev_req;
        end
    end

    // ****************************************************************
    // Script fetch port.
    // ****************************************************************
    // Script fetches: one cycle for registered memory data.
    always @(posedge clk) begin
        if (reset) begin
            fpend_reg      <= 1'b0;
            fetch_internal <= 1'b0;
            fetch_valid    <= 1'b0;
            fetch_data     <= `ISR_ZERO32;
        end else begin
            fetch_internal <= fetch_take;
            fpend_reg      <= fetch_take;
            fetch_valid    <= fpend_reg;
            if (fpend_reg) begin
                fetch_data <= rd_data;
            end
        end
    end

    // ****************************************************************
    // Target handshake.
    // ****************************************************************
    // Target handshake: claim, 3 wait states, then ready for one cycle.
    // The write lands on the last wait state, so ready marks it done.
    always @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            wait_reg  <= 2'd0;
            twr_reg   <= 1'b0;
            tbe_reg   <= 4'h0;
            tidx_reg  <= 10'h000;
            twd_reg   <= `ISR_ZERO32;
            tgt_claim <= 1'b0;
            tgt_ready <= 1'b0;
            tgt_rdata <= `ISR_ZERO32;
        end else begin
            tgt_ready <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (tgt_req && tgt_hit && !(fetch_req && fetch_hit)) begin
                        tgt_claim <= 1'b1;
                        twr_reg   <= tgt_write;
                        tbe_reg   <= ~tgt_be_n;
                        tidx_reg  <= tgt_addr[`ISR_IDX_MSB:`ISR_IDX_LSB];
                        twd_reg   <= tgt_wdata;
                        wait_reg  <= `ISR_WAIT_STATES - 2'd1;
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (wait_reg == 2'd0) begin
                        tgt_ready <= 1'b1;
                        tgt_rdata <= rd_data;
                        state_reg <= ST_DONE;
                    end else begin
                        wait_reg <= wait_reg - 2'd1;
                    end
                end
                ST_DONE: begin
                    tgt_claim <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- verification/isr_ram_asserts.sv
`timescale 1ns/1ps
// Watches the script RAM ports for handshake, decode and mirror behaviour.
module isr_ram_asserts (
    input wire logic        clk, reset, base_wr, chip_test_bit3, tgt_req, tgt_claim,
    input wire logic        tgt_ready, fetch_req, fetch_internal, fetch_valid, dev_req,
    input wire logic        dev_use_pci, ram_enabled,
    input wire logic [31:0] base_wr_data, scratch_value, second_scratch_reg, tgt_addr,
    input wire logic [31:0] fetch_addr, ram_base
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Target wait states between claim and ready.
    sequence s_wait;
        !tgt_ready [*3];
    endsequence
    a_ready_delay: assert property ($rose(tgt_claim) |-> s_wait ##1 tgt_ready)
        else $error("ready late");
    a_claim_drop: assert property (tgt_ready |-> tgt_claim ##1 (!tgt_claim && !tgt_ready))
        else $error("claim held");
    a_claim_hit: assert property ($rose(tgt_claim) |-> $past(tgt_req) && ram_enabled
        && $past(tgt_addr[31:12]) == ram_base[31:12]) else $error("bad claim");
    a_fetch_hit: assert property (fetch_internal |-> $past(fetch_req) && ram_enabled
        && $past(fetch_addr[31:12]) == ram_base[31:12]) else $error("bad fetch");
    a_fetch_data: assert property (fetch_internal |=> fetch_valid)
        else $error("no fetch data");
    a_dev_pci: assert property (dev_req |=> dev_use_pci)
        else $error("no master cycle");
    a_base_load: assert property (base_wr |=> ram_base == {$past(base_wr_data[31:12]), 12'h000})
        else $error("base not loaded");
    a_base_mirror: assert property (!$past(reset) |-> second_scratch_reg ==
        ($past(chip_test_bit3) ? $past(ram_base) : $past(scratch_value))) else $error("bad scratch");
endmodule
bind isr_ram isr_ram_asserts u_chk (.*);

//--- verification/isr_bfm.sv
`timescale 1ns/1ps
// Bus master and script fetcher on the far side of the RAM.
module isr_bfm (
    input  wire logic   clk, tgt_ready,
    output logic        tgt_req, tgt_write, fetch_req, fetch_table,
    output logic [31:0] tgt_addr, tgt_wdata, fetch_addr,
    output logic [3:0]  tgt_be_n
);
    // Idle lines at time zero.
    initial begin
        {tgt_req, tgt_write, fetch_req, fetch_table, tgt_be_n} = 8'h0F;
        {tgt_addr, tgt_wdata, fetch_addr} = 96'h0;
    end
    // One access held until ready or at most 20 more clocks; released lines then show scrambled values.
    task acc(input logic w, input logic [31:0] a, input logic [3:0] b, input logic [31:0] d);
        int n;
        n = 0;
        {tgt_req, tgt_write, tgt_be_n, tgt_addr, tgt_wdata} <= {1'b1, w, b, a, d};
        @(posedge clk);
        while (tgt_ready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        {tgt_req, tgt_be_n, tgt_addr, tgt_wdata} <= {1'b0, ~b, ~a, ~d};
        repeat (2) @(posedge clk);
    endtask
    // One script fetch.
    task ftc(input logic t, input logic [31:0] a);
        {fetch_req, fetch_table, fetch_addr} <= {1'b1, t, a};
        @(posedge clk);
        {fetch_req, fetch_addr} <= {1'b0, ~a};
        repeat (3) @(posedge clk);
    endtask
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        clk, reset, ram_enable_strap, base_wr, chip_test_bit3, dev_req, tgt_req;
    logic        tgt_write, tgt_claim, tgt_ready, fetch_req, fetch_table, fetch_internal;
    logic        fetch_valid, dev_use_pci, ram_enabled, seen;
    logic [31:0] base_wr_data, scratch_value, second_scratch_reg, tgt_addr, tgt_wdata;
    logic [31:0] tgt_rdata, fetch_addr, fetch_data, ram_base, a, d, m;
    logic [3:0]  tgt_be_n, b;
    logic [31:0] rq[$], fq[$];
    int          miscompares, checks, cyc;
    isr_ram dut (.*);
    isr_bfm bfm (.*);
    // Clock at 50 ns period.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %0t %h %h", $time, s, e);
        end
    endtask
    task end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task rst(input logic s);
        reset <= 1'b1;
        ram_enable_strap <= s;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // Compares data against the oldest note and bounds the run.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            end_of_test();
        end
        if (tgt_claim === 1'b1)
            seen = 1'b1;
        if (tgt_ready === 1'b1 && tgt_write === 1'b0)
            chk(tgt_rdata, rq.pop_front());
        if (fetch_valid === 1'b1)
            chk(fetch_data, fq.pop_front());
    end
    // Main sequence.
    initial begin
        {reset, base_wr, chip_test_bit3, dev_req, seen} = 5'h10;
        {base_wr_data, scratch_value} = 64'h0;
        ram_enable_strap = 1'b1;
        void'($urandom(99));
        rst(1'b1);
        chk(32'(ram_enabled), 32'h1);
        {base_wr, chip_test_bit3, base_wr_data, scratch_value} <= {2'h3, 32'hABCD_E123, $urandom};
        @(posedge clk);
        base_wr <= 1'b0;
        repeat (3) @(posedge clk);
        chk(ram_base, 32'hABCD_E000);
        chk(second_scratch_reg, 32'hABCD_E000);
        chip_test_bit3 <= 1'b0;
        repeat (2) @(posedge clk);
        chk(second_scratch_reg, scratch_value);
        for (int i = 0; i < 8; i++) begin
            a = 32'hABCD_E000 + (i < 2 ? i * 32'hFFC : $urandom & 32'hFFC);
            d = $urandom;
            m = $urandom;
            b = 4'($urandom);
            bfm.acc(1'b1, a, 4'h0, d);
            bfm.acc(1'b1, a, b, m);
            for (int k = 0; k < 4; k++)
                if (!b[k])
                    d[8*k +: 8] = m[8*k +: 8];
            rq.push_back(d);
            bfm.acc(1'b0, a, 4'h0, 32'h0);
            fq.push_back(d);
            bfm.ftc(i[0], a);
        end
        dev_req <= 1'b1;
        @(posedge clk);
        dev_req <= 1'b0;
        @(posedge clk);
        chk(32'(dev_use_pci), 32'h1);
        seen = 1'b0;
        bfm.acc(1'b0, 32'hABCD_F000, 4'h0, 32'h0);
        chk(32'(seen), 32'h0);
        rst(1'b0);
        chk(32'(ram_enabled), 32'h0);
        bfm.acc(1'b0, 32'h0, 4'h0, 32'h0);
        chk(32'(seen), 32'h0);
        end_of_test();
    end
endmodule
